//--- test/oss_fe_model.sv
/* Front end model: answers each LED pulse with one conversion.
   Assumes pulses are spaced wider than DLY clocks. */
`timescale 1ns/1ps
module oss_fe_model #(
  parameter DLY = 3,
  parameter [13:0] VAL = 14'h3FFF
) (
  input  wire        clk_sys_i,
  input  wire        led_pulse_i,
  input  wire        led_slot_i,
  input  wire [1:0]  diode_i,
  output reg         conv_valid_o,
  output reg  [13:0] conv_data_o,
  output reg  [1:0]  sel0_o,
  output reg  [1:0]  sel1_o
);
  initial begin
    conv_valid_o = 1'b0;
    conv_data_o = ~VAL;
    sel0_o = 2'h3;
    sel1_o = 2'h3;
  end
  // Data shows only with valid; idle value is the inverse
  always @(posedge clk_sys_i) begin
    if (led_pulse_i) begin
      if (led_slot_i) sel1_o <= diode_i;
      else sel0_o <= diode_i;
      repeat (DLY) @(negedge clk_sys_i);
      conv_valid_o <= 1'b1;
      conv_data_o <= VAL;
      @(negedge clk_sys_i);
      conv_valid_o <= 1'b0;
      conv_data_o <= ~VAL;
    end
  end
endmodule // oss_fe_model

//--- test/oss_sequencer_properties.sv
/* Port assertions for the optical sample sequencer.
   Assumes one clock domain; bound to every oss_sequencer instance. */
`timescale 1ns/1ps
module oss_seq_props (
  // Clock and reset
  input wire        clk_sys_i,
  input wire        rst_i,
  // Register access
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  // Pins and front end
  input wire        int_pin_o,
  input wire        int_pin_oe_o,
  input wire        powerdown_status_pin_o,
  input wire        powerdown_status_pin_oe_o,
  input wire        led_pulse_o,
  input wire [1:0]  diode_current_inputs_o,
  // FIFO read side
  input wire        fifo_valid_o,
  input wire [31:0] fifo_data_o,
  input wire        fifo_ready_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_int_idle; int_pin_o == 1'b0; endproperty
  a_int_idle: assert property (p_int_idle) else $error("int pin driven high");
  property p_pin_oe;
    (reg_wr_i && reg_addr_i == 8'h4F) ##1 !(reg_wr_i && reg_addr_i == 8'h4F) |=>
      {int_pin_oe_o, powerdown_status_pin_oe_o} ==
      ~{$past(reg_wdata_i[1], 2), $past(reg_wdata_i[5], 2)};
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enables wrong");
  property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_pulse; led_pulse_o |=> !led_pulse_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_stby;
    powerdown_status_pin_o |-> !led_pulse_o && diode_current_inputs_o == 2'h0;
  endproperty
  a_stby: assert property (p_stby) else $error("activity in standby");
  property p_fifo_hi; fifo_valid_o |-> fifo_data_o[31:20] == 12'h000; endproperty
  a_fifo_hi: assert property (p_fifo_hi) else $error("fifo word too wide");
  property p_fifo_hold;
    fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_data_o);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo word lost");
  property p_mode_rd;
    (reg_wr_i && reg_addr_i == 8'h10) ##1 (reg_rd_i && reg_addr_i == 8'h10) |=>
      reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 2);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
endmodule // oss_seq_props
bind oss_sequencer oss_seq_props i_oss_seq_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .int_pin_o(int_pin_o), .int_pin_oe_o(int_pin_oe_o),
  .powerdown_status_pin_o(powerdown_status_pin_o),
  .powerdown_status_pin_oe_o(powerdown_status_pin_oe_o), .led_pulse_o(led_pulse_o),
  .diode_current_inputs_o(diode_current_inputs_o), .fifo_valid_o(fifo_valid_o),
  .fifo_data_o(fifo_data_o), .fifo_ready_i(fifo_ready_i));

//--- test/tb_top.sv
/* Register-level bench of the optical sample sequencer.
   Assumes a 100 MHz clock and an external tick on the status pin. */
`timescale 1ns/1ps
module tb_top;
  reg clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, fifo_ready_i = 0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg pd_pin = 0, run = 0, int_pin = 0;
  reg [3:0] tk = 4'h0;
  wire [15:0] rdata;
  wire int_oe, pd_o, pd_oe, pulse, slot, cv, fv;
  wire [1:0] dio, sel0, sel1;
  wire [13:0] cd;
  wire [31:0] fd;
  integer fails = 0, checks_done = 0, i;
  always #5 clk_sys_i = ~clk_sys_i;
  // Status pin toggles every ten clocks as the external 32 kHz tick
  always @(negedge clk_sys_i) if (run) begin
    tk <= (tk == 4'h9) ? 4'h0 : tk + 4'h1;
    if (tk == 4'h9) pd_pin <= ~pd_pin;
  end
  oss_sequencer i_oss_sequencer (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .int_pin_i(int_pin), .int_pin_o(),
    .int_pin_oe_o(int_oe), .powerdown_status_pin_i(pd_pin),
    .powerdown_status_pin_o(pd_o), .powerdown_status_pin_oe_o(pd_oe),
    .led_pulse_o(pulse), .led_slot_o(slot), .diode_current_inputs_o(dio),
    .conv_valid_i(cv), .conv_data_i(cd), .fifo_valid_o(fv), .fifo_data_o(fd),
    .fifo_ready_i(fifo_ready_i));
  oss_fe_model i_oss_fe_model (.clk_sys_i(clk_sys_i), .led_pulse_i(pulse),
    .led_slot_i(slot), .diode_i(dio), .conv_valid_o(cv), .conv_data_o(cd),
    .sel0_o(sel0), .sel1_o(sel1));
  task chk(input [31:0] got, input [31:0] exp); begin
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end endtask
  // Strobes stay up between calls so accesses run back to back
  task wr(input [7:0] a, input [15:0] d); begin
    {reg_wr_i, reg_rd_i} = 2'b10;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
  end endtask
  task rd(input [7:0] a, input [15:0] e); begin
    {reg_wr_i, reg_rd_i} = 2'b01;
    reg_addr_i = a;
    @(negedge clk_sys_i);
    chk({16'h0000, rdata}, {16'h0000, e});
  end endtask
  task pop(input [31:0] e); begin
    {reg_wr_i, reg_rd_i} = 2'b00;
    for (i = 0; i < 5000 && fv !== 1'b1; i = i + 1) @(negedge clk_sys_i);
    chk(fd, e);
    fifo_ready_i = 1'b1;
    @(negedge clk_sys_i);
    fifo_ready_i = 1'b0;
  end endtask
  task idle(input integer n); begin
    {reg_wr_i, reg_rd_i} = 2'b00;
    repeat (n) @(negedge clk_sys_i);
  end endtask
  task report_and_stop; begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  initial begin
    // About ten times the expected length of all tests
    #200000;
    fails = fails + 1;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 0;
    rd(8'h10, 16'h0000);
    rd(8'h12, 16'h0020);
    rd(8'h4B, 16'h2612);
    rd(8'h14, 16'h0000);
    rd(8'h00, 16'h0000);
    chk(pd_o, 1);
    $display("test reset done");
    wr(8'h10, 16'h0001);
    rd(8'h10, 16'h0001);
    wr(8'h14, 16'h0450);
    rd(8'h14, 16'h0450);
    $display("test registers done");
    wr(8'h4F, 16'h0020);
    run = 1;
    wr(8'h4B, 16'h2792);
    wr(8'h31, 16'h0200);
    wr(8'h36, 16'h0200);
    wr(8'h15, 16'h0110);
    wr(8'h11, 16'h0003);
    wr(8'h12, 16'h0014);
    chk({int_oe, pd_oe, pd_o}, 3'b100);
    wr(8'h10, 16'h0002);
    pop(32'h00007FFE);
    pop(32'h00007FFE);
    rd(8'h70, 16'hFFFC);
    rd(8'h71, 16'h0000);
    rd(8'h72, 16'hFFFC);
    chk({sel0, sel1}, 4'b0110);
    $display("test sampling done");
    wr(8'h10, 16'h0001);
    wr(8'h10, 16'h0000);
    rd(8'h14, 16'h0450);
    chk(pd_o, 1);
    $display("test standby done");
    wr(8'h10, 16'h0001);
    wr(8'h4F, 16'h0026);
    wr(8'h38, 16'h4000);
    wr(8'h15, 16'h0100);
    wr(8'h10, 16'h0002);
    idle(100);
    rd(8'h74, 16'h0001);
    chk(int_oe, 0);
    // Sync edge: start lands one to two ticks later
    int_pin = 1'b1;
    idle(15);
    rd(8'h74, 16'h0001);
    idle(25);
    rd(8'h74, 16'h0002);
    pop(32'h00007FFE);
    int_pin = 1'b0;
    idle(400);
    int_pin = 1'b1;
    pop(32'h00007FFE);
    idle(200);
    chk(fv, 0);
    rd(8'h70, 16'h7FFE);
    rd(8'h72, 16'hFFFC);
    $display("test external sync done");
    report_and_stop;
  end
endmodule // tb_top

//--- verilog/oss_accum.v
/*
  Per-slot accumulator: sums 14-bit conversions into a sample clipped to
  20 bits, then sums N samples (N = 2^log2n) into a 27-bit result.
  Assumes done_i comes once per sample after its last conversion.
*/
`timescale 1ns/1ps
`include "oss_defines.vh"
module oss_accum (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Sample input
  input  wire        conv_valid_i,
  input  wire [13:0] conv_i,
  input  wire        done_i,
  input  wire [2:0]  log2n_i,
  // Results
  output reg  [26:0] sum_o,
  output reg  [19:0] avg_o,
  output reg         new_o
);

  reg  [19:0] pulse_sum_r;
  reg  [26:0] run_sum_r;
  reg  [7:0]  nsamp_r;
  wire [20:0] pulse_add;
  wire [26:0] total;
  wire [26:0] total_div;
  wire [7:0]  n_last;

  assign pulse_add = {1'b0, pulse_sum_r} + {7'h00, conv_i};
  assign total     = run_sum_r + {7'h00, pulse_sum_r};
  assign total_div = total >> log2n_i;
  assign n_last    = (8'h01 << log2n_i) - 8'h01;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pulse_sum_r <= 20'h00000;
      run_sum_r   <= 27'h0000000;
      nsamp_r     <= 8'h00;
      sum_o       <= 27'h0000000;
      avg_o       <= 20'h00000;
      new_o       <= 1'b0;
    end else begin
      new_o <= 1'b0;
      if (done_i) begin
        pulse_sum_r <= 20'h00000;
        if (nsamp_r >= n_last) begin
          sum_o     <= total;
          avg_o     <= total_div[19:0];
          new_o     <= 1'b1;
          run_sum_r <= 27'h0000000;
          nsamp_r   <= 8'h00;
        end else begin
          run_sum_r <= total;
          nsamp_r   <= nsamp_r + 8'h01;
        end
      end else if (conv_valid_i) begin
        pulse_sum_r <= pulse_add[20] ? `OSS_CLIP_MAX : pulse_add[19:0];
      end
    end
  end

endmodule // oss_accum

//--- verilog/oss_defines.vh
/*
  Constants of the optical sample sequencer: register offsets, field
  positions, reset values, mode and selection codes, timing counts.
  Assumes a 100 MHz system clock and 16-bit register words.
*/
`ifndef OSS_DEFINES_VH
`define OSS_DEFINES_VH

// Register offsets
`define OSS_A_MODE     8'h10
`define OSS_A_FIFOCFG  8'h11
`define OSS_A_FREQ     8'h12
`define OSS_A_SWITCH   8'h14
`define OSS_A_AVG      8'h15
`define OSS_A_CNT_A    8'h31
`define OSS_A_CNT_B    8'h36
`define OSS_A_SLOTCFG  8'h38
`define OSS_A_CLK      8'h4B
`define OSS_A_PIN      8'h4F
`define OSS_A_DA_LO    8'h70
`define OSS_A_DA_HI    8'h71
`define OSS_A_DB_LO    8'h72
`define OSS_A_DB_HI    8'h73
`define OSS_A_STATUS   8'h74

// Field positions
`define OSS_F_MODE     1:0
`define OSS_F_SEL_B    11:8
`define OSS_F_SEL_A    7:4
`define OSS_F_CNT      15:8
`define OSS_F_EXTSYNC  14
`define OSS_F_TRIM     5:0
`define OSS_F_CK_EN    7
`define OSS_F_CK_BYP   8
`define OSS_F_SYNCSEL  3:2
`define OSS_F_INTBUF   1
`define OSS_F_PDBUF    5
`define OSS_F_AVG_A    6:4
`define OSS_F_AVG_B    10:8
`define OSS_F_FIFO_A   0
`define OSS_F_FIFO_B   1

// Reset values
`define OSS_RST_CLK    16'h2612
`define OSS_RST_FREQ   16'h0020
`define OSS_RST_ZERO   16'h0000

// Mode codes
`define OSS_MODE_STBY  2'h0
`define OSS_MODE_PROG  2'h1
`define OSS_MODE_NORM  2'h2

// Diode selection codes
`define OSS_SEL_FLOAT  4'h0
`define OSS_SEL_ALL    4'h1
`define OSS_SEL_UPPER  4'h4
`define OSS_SEL_LOWER  4'h5

// Sync source codes
`define OSS_SYNC_INT   2'h1
`define OSS_SYNC_POWERDOWN_STATUS_PIN  2'h2

// Timing
`define OSS_SYS_HZ     100000000
`define OSS_LCK_HZ     32768
`define OSS_TRIM_MID   12'h020
`define OSS_LCK_DIV    (`OSS_SYS_HZ / `OSS_LCK_HZ)
`define OSS_TICK_NS    (1000000000 / `OSS_LCK_HZ)
`define OSS_T1_US      68
`define OSS_T2_US      20
`define OSS_SLEEP_US   222
`define OSS_T1_TICKS   ((`OSS_T1_US * 1000 + `OSS_TICK_NS - 1) / `OSS_TICK_NS)
`define OSS_T2_TICKS   ((`OSS_T2_US * 1000 + `OSS_TICK_NS - 1) / `OSS_TICK_NS)
`define OSS_SLP_TICKS  ((`OSS_SLEEP_US * 1000 + `OSS_TICK_NS - 1) / `OSS_TICK_NS)

// Data widths
`define OSS_CLIP_MAX   20'hFFFFF

`endif

//--- verilog/oss_fifo.v
/*
  Synchronous FIFO with flip-flop storage, valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module oss_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset
  input  wire          clk_sys_i,
  input  wire          rst_i,
  // Fill side
  input  wire          in_valid_i,
  input  wire [W-1:0]  in_data_i,
  output wire          in_ready_o,
  // Drain side
  output wire          out_valid_o,
  output wire [W-1:0]  out_data_o,
  input  wire          out_ready_i
);

  reg [W-1:0]  mem_r [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  wire         push;
  wire         pop;

  assign in_ready_o  = (count_r != D[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // oss_fifo

//--- verilog/oss_sequencer.v
/*
  Optical sample sequencer: register file, 32 kHz tick generation,
  external sync and clock, mode handling, two-slot sampling sequence,
  per-slot accumulation and the output FIFO.
  Assumes register accesses and pins are synchronous to clk_sys_i and
  the front end answers each LED pulse with one conversion.
*/
`timescale 1ns/1ps
`include "oss_defines.vh"
module oss_sequencer (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Register access
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  output reg  [15:0] reg_rdata_o,
  // Interrupt and power-down status pins
  input  wire        int_pin_i,
  output reg         int_pin_o,
  output reg         int_pin_oe_o,
  input  wire        powerdown_status_pin_i,
  output reg         powerdown_status_pin_o,
  output reg         powerdown_status_pin_oe_o,
  // Front end
  output reg         led_pulse_o,
  output reg         led_slot_o,
  output reg  [1:0]  diode_current_inputs_o,
  input  wire        conv_valid_i,
  input  wire [13:0] conv_data_i,
  // FIFO read side
  output reg         fifo_valid_o,
  output reg  [31:0] fifo_data_o,
  input  wire        fifo_ready_i
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_WAIT  = 3'h1;
  localparam ST_PULSE = 3'h2;
  localparam ST_COMP  = 3'h3;
  localparam ST_SLEEP = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // Register file
  reg [15:0] mode_r;
  reg [15:0] fifocfg_r;
  reg [15:0] freq_r;
  reg [15:0] switch_r;
  reg [15:0] avg_r;
  reg [15:0] cnt_a_r;
  reg [15:0] cnt_b_r;
  reg [15:0] slotcfg_r;
  reg [15:0] clkcfg_r;
  reg [15:0] pincfg_r;

  wire [26:0] sum_w [0:1];
  wire [19:0] avg_w [0:1];
  wire [1:0]  new_w;
  reg  [2:0]  state_r;
  reg  [15:0] rdata_nxt;

  // Standby changes no register, so contents survive it
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_r    <= {14'h0000, `OSS_MODE_STBY};
      fifocfg_r <= `OSS_RST_ZERO;
      freq_r    <= `OSS_RST_FREQ;
      switch_r  <= `OSS_RST_ZERO;
      avg_r     <= `OSS_RST_ZERO;
      cnt_a_r   <= `OSS_RST_ZERO;
      cnt_b_r   <= `OSS_RST_ZERO;
      slotcfg_r <= `OSS_RST_ZERO;
      clkcfg_r  <= `OSS_RST_CLK;
      pincfg_r  <= `OSS_RST_ZERO;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OSS_A_MODE:    mode_r    <= reg_wdata_i;
        `OSS_A_FIFOCFG: fifocfg_r <= reg_wdata_i;
        `OSS_A_FREQ:    freq_r    <= reg_wdata_i;
        `OSS_A_SWITCH:  switch_r  <= reg_wdata_i;
        `OSS_A_AVG:     avg_r     <= reg_wdata_i;
        `OSS_A_CNT_A:   cnt_a_r   <= reg_wdata_i;
        `OSS_A_CNT_B:   cnt_b_r   <= reg_wdata_i;
        `OSS_A_SLOTCFG: slotcfg_r <= reg_wdata_i;
        `OSS_A_CLK:     clkcfg_r  <= reg_wdata_i;
        `OSS_A_PIN:     pincfg_r  <= reg_wdata_i;
        default:        mode_r    <= mode_r;
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `OSS_A_MODE:    rdata_nxt = mode_r;
      `OSS_A_FIFOCFG: rdata_nxt = fifocfg_r;
      `OSS_A_FREQ:    rdata_nxt = freq_r;
      `OSS_A_SWITCH:  rdata_nxt = switch_r;
      `OSS_A_AVG:     rdata_nxt = avg_r;
      `OSS_A_CNT_A:   rdata_nxt = cnt_a_r;
      `OSS_A_CNT_B:   rdata_nxt = cnt_b_r;
      `OSS_A_SLOTCFG: rdata_nxt = slotcfg_r;
      `OSS_A_CLK:     rdata_nxt = clkcfg_r;
      `OSS_A_PIN:     rdata_nxt = pincfg_r;
      `OSS_A_DA_LO:   rdata_nxt = sum_w[0][15:0];
      `OSS_A_DA_HI:   rdata_nxt = {5'h00, sum_w[0][26:16]};
      `OSS_A_DB_LO:   rdata_nxt = sum_w[1][15:0];
      `OSS_A_DB_HI:   rdata_nxt = {5'h00, sum_w[1][26:16]};
      `OSS_A_STATUS:  rdata_nxt = {13'h0000, state_r};
      default:        rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins: input buffers, sync source, external clock
  wire       int_buf_en  = pincfg_r[`OSS_F_INTBUF];
  wire       pd_buf_en   = pincfg_r[`OSS_F_PDBUF];
  wire       int_in      = int_pin_i & int_buf_en;
  wire       pd_in       = powerdown_status_pin_i & pd_buf_en;
  wire [1:0] sync_sel    = pincfg_r[`OSS_F_SYNCSEL];
  wire       ext_clk_on  = clkcfg_r[`OSS_F_CK_EN] & clkcfg_r[`OSS_F_CK_BYP];
  wire       ext_sync_on = slotcfg_r[`OSS_F_EXTSYNC];
  wire       normal      = (mode_r[`OSS_F_MODE] == `OSS_MODE_NORM);
  reg        sync_in;
  reg        sync_d_r;
  reg        pd_d_r;

  always @* begin
    case (sync_sel)
      `OSS_SYNC_INT:  sync_in = int_in;
      `OSS_SYNC_POWERDOWN_STATUS_PIN: sync_in = pd_in;
      default:        sync_in = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_d_r                  <= 1'b0;
      pd_d_r                    <= 1'b0;
      int_pin_o                 <= 1'b0;
      int_pin_oe_o              <= 1'b1;
      powerdown_status_pin_o    <= 1'b1;
      powerdown_status_pin_oe_o <= 1'b1;
    end else begin
      sync_d_r                  <= sync_in;
      pd_d_r                    <= pd_in;
      int_pin_o                 <= 1'b0;
      int_pin_oe_o              <= ~int_buf_en;
      powerdown_status_pin_o    <= (mode_r[`OSS_F_MODE] == `OSS_MODE_STBY);
      powerdown_status_pin_oe_o <= ~pd_buf_en;
    end
  end

  wire sync_rise = sync_in & ~sync_d_r;
  wire pd_rise   = pd_in & ~pd_d_r;

  //////////////////////////////////////////////////////////////////////////
  // 32 kHz tick: trimmed divider or external clock edge
  reg  [11:0] div_cnt_r;
  wire [31:0] div_full = `OSS_LCK_DIV + {6'h00, clkcfg_r[`OSS_F_TRIM]}
                         - `OSS_TRIM_MID;
  wire [11:0] div_len = div_full[11:0];
  wire        div_end = (div_cnt_r >= div_len - 12'h001);
  wire        tick    = ext_clk_on ? pd_rise : div_end;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_cnt_r <= 12'h000;
    end else if (div_end) begin
      div_cnt_r <= 12'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample sequencer
  reg        slot_r;
  reg [7:0]  sent_r;
  reg [7:0]  rcvd_r;
  reg [3:0]  wait_r;
  reg [15:0] period_r;
  reg        sync_arm_r;
  reg        sync_go_r;
  reg [1:0]  done_r;
  wire [31:0] t1_full  = `OSS_T1_TICKS;
  wire [31:0] t2_full  = `OSS_T2_TICKS;
  wire [31:0] slp_full = `OSS_SLP_TICKS;
  wire       fifo_in_ready;
  wire [7:0] n_a    = cnt_a_r[`OSS_F_CNT];
  wire [7:0] n_b    = cnt_b_r[`OSS_F_CNT];
  wire       used_a = (n_a != 8'h00);
  wire       used_b = (n_b != 8'h00);
  wire [7:0] n_cur  = slot_r ? n_b : n_a;
  wire       start_ok = ext_sync_on ? (sync_go_r & tick)
                        : (tick & (period_r >= freq_r));

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      slot_r      <= 1'b0;
      sent_r      <= 8'h00;
      rcvd_r      <= 8'h00;
      wait_r      <= 4'h0;
      period_r    <= 16'h0000;
      sync_arm_r  <= 1'b0;
      sync_go_r   <= 1'b0;
      done_r      <= 2'b00;
      led_pulse_o <= 1'b0;
    end else begin
      led_pulse_o <= 1'b0;
      done_r      <= 2'b00;
      if (tick && period_r != 16'hFFFF) begin
        period_r <= period_r + 16'h0001;
      end
      // Edge arms, next tick confirms, following tick starts
      if (state_r != ST_WAIT || !ext_sync_on) begin
        sync_arm_r <= 1'b0;
        sync_go_r  <= 1'b0;
      end else if (sync_rise) begin
        sync_arm_r <= 1'b1;
      end else if (tick && sync_arm_r) begin
        sync_arm_r <= 1'b0;
        sync_go_r  <= 1'b1;
      end
      if (!normal) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            state_r  <= ST_WAIT;
            period_r <= freq_r;
          end
          ST_WAIT: begin
            // A full FIFO holds the next sample back
            if (start_ok && fifo_in_ready && (used_a || used_b)) begin
              state_r   <= ST_PULSE;
              slot_r    <= ~used_a;
              sent_r    <= 8'h00;
              rcvd_r    <= 8'h00;
              period_r  <= 16'h0000;
              sync_go_r <= 1'b0;
            end
          end
          ST_PULSE: begin
            if (tick && sent_r != n_cur) begin
              led_pulse_o <= 1'b1;
              sent_r      <= sent_r + 8'h01;
            end
            if (conv_valid_i) begin
              rcvd_r <= rcvd_r + 8'h01;
            end
            if (rcvd_r == n_cur) begin
              state_r <= ST_COMP;
              wait_r  <= slot_r ? t2_full[3:0] : t1_full[3:0];
            end
          end
          ST_COMP: begin
            if (tick) begin
              if (wait_r == 4'h1) begin
                done_r[slot_r] <= 1'b1;
                if (!slot_r && used_b) begin
                  state_r <= ST_PULSE;
                  slot_r  <= 1'b1;
                  sent_r  <= 8'h00;
                  rcvd_r  <= 8'h00;
                end else begin
                  state_r <= ST_SLEEP;
                  wait_r  <= slp_full[3:0];
                end
              end else begin
                wait_r <= wait_r - 4'h1;
              end
            end
          end
          ST_SLEEP: begin
            if (tick) begin
              if (wait_r == 4'h1) begin
                state_r <= ST_WAIT;
              end else begin
                wait_r <= wait_r - 4'h1;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Diode group per active slot; reserved codes leave all open
  wire [3:0] sel_cur = slot_r ? switch_r[`OSS_F_SEL_B]
                              : switch_r[`OSS_F_SEL_A];
  reg  [1:0] diode_nxt;

  always @* begin
    case (sel_cur)
      `OSS_SEL_ALL:   diode_nxt = 2'b11;
      `OSS_SEL_UPPER: diode_nxt = 2'b10;
      `OSS_SEL_LOWER: diode_nxt = 2'b01;
      default:        diode_nxt = 2'b00;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      diode_current_inputs_o <= 2'b00;
      led_slot_o             <= 1'b0;
    end else begin
      diode_current_inputs_o <= (state_r == ST_PULSE) ? diode_nxt : 2'b00;
      led_slot_o             <= slot_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-slot accumulation
  wire [2:0] log2n [0:1];
  assign log2n[0] = avg_r[`OSS_F_AVG_A];
  assign log2n[1] = avg_r[`OSS_F_AVG_B];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_slot
      oss_accum u_accum (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .conv_valid_i (conv_valid_i & (state_r == ST_PULSE)
                       & (slot_r == g)),
        .conv_i       (conv_data_i),
        .done_i       (done_r[g]),
        .log2n_i      (log2n[g]),
        .sum_o        (sum_w[g]),
        .avg_o        (avg_w[g]),
        .new_o        (new_w[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // FIFO feed and output stage
  wire fifo_a  = fifocfg_r[`OSS_F_FIFO_A];
  wire same_n  = (log2n[0] == log2n[1]);
  wire fifo_b  = fifocfg_r[`OSS_F_FIFO_B] & (same_n | ~fifo_a);
  wire wr_a    = new_w[0] & fifo_a;
  wire wr_b    = new_w[1] & fifo_b;
  wire [31:0] fifo_in = {12'h000, wr_a ? avg_w[0] : avg_w[1]};
  wire        fo_valid;
  wire [31:0] fo_data;
  wire        fo_take = fo_valid & (~fifo_valid_o | fifo_ready_i);

  oss_fifo #(
    .W  (32),
    .D  (16),
    .AW (4)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_a | wr_b),
    .in_data_i   (fifo_in),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fo_valid),
    .out_data_o  (fo_data),
    .out_ready_i (~fifo_valid_o | fifo_ready_i)
  );

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      fifo_valid_o <= 1'b0;
      fifo_data_o  <= 32'h00000000;
    end else if (fo_take) begin
      fifo_valid_o <= 1'b1;
      fifo_data_o  <= fo_data;
    end else if (fifo_ready_i) begin
      fifo_valid_o <= 1'b0;
    end
  end

endmodule // oss_sequencer
